// ---- pkg/tdmssp_pkg.sv ----
// package: constants and types shared by the serial voice/data port
package tdmssp_pkg;
    typedef logic [7:0] tdmssp_byte_t;
    typedef enum logic {SS_IDLE, SS_SLOT} tdmssp_slot_t;

    // control port addresses of the channel data registers
    localparam tdmssp_byte_t C_CHAN_ADDR = 8'h14;
    localparam tdmssp_byte_t D_CHAN_ADDR = 8'h15;
    // values after power-on reset; the two transmit values also after software reset
    localparam tdmssp_byte_t C_TX_RESET = 8'hFF;
    localparam tdmssp_byte_t D_TX_RESET = 8'hFF;
    localparam tdmssp_byte_t RX_RESET = 8'h00;
    // quiet byte sent in a strobed slot with no transmit path
    localparam tdmssp_byte_t QUIET_CODE = 8'hFF;
    // frame slot positions
    localparam logic [4:0] SLOT_D = 5'h00;
    localparam logic [4:0] SLOT_C = 5'h01;
    localparam logic [4:0] SLOT_B1 = 5'h02;
    localparam logic [4:0] SLOT_B2 = 5'h03;
    // d channel pacing: last frame of a byte, bits per frame, interrupt bit cell
    localparam logic [2:0] D_FAST_LAST_FRAME = 3'h3;
    localparam logic [2:0] D_SLOW_LAST_FRAME = 3'h7;
    localparam logic [2:0] D_FAST_BITS = 3'h2;
    localparam logic [2:0] D_SLOW_BITS = 3'h1;
    localparam logic [2:0] D_FAST_IRQ_BIT = 3'h2;
    localparam logic [2:0] D_SLOW_IRQ_BIT = 3'h1;
    // regenerated bit clock: master clock cycles per bit, minus one, and half
    localparam logic [4:0] ASYNC_LAST_128 = 5'h1F;
    localparam logic [4:0] ASYNC_HALF_128 = 5'h10;
    localparam logic [4:0] ASYNC_LAST_256 = 5'h0F;
    localparam logic [4:0] ASYNC_HALF_256 = 5'h08;
    // synchroniser reset levels: din, strobe, frame pulse (idle high), clock
    localparam logic [3:0] SYNC_RESET = 4'h2;
endpackage

// ---- pkg/tdmssp_tim_if.sv ----
// interface: synchronised link timing from the edge finder to the port logic
`timescale 1ns/1ps
interface tdmssp_tim_if;
    logic mclk_rise;
    logic mclk_fall;
    logic fp_low;
    logic stb;
    logic stb_rise;
    logic din;
    logic bit_rise;
    logic bit_fall;
    modport gen (output mclk_rise, mclk_fall, fp_low, stb, stb_rise, din, bit_rise, bit_fall);
    modport sink (input mclk_rise, mclk_fall, fp_low, stb, stb_rise, din, bit_rise, bit_fall);
endinterface

// ---- src/tdmssp_clk_gen.sv ----
// edge finder, pin synchronisers and regenerated bit clock for strobed mode
`timescale 1ns/1ps
module tdmssp_clk_gen #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic master_clock_in,
    input wire logic frame_pulse_input,
    input wire logic slot_strobe,
    input wire logic tdm_serial_in,
    input wire logic async_select,
    input wire logic bit_rate_select_hi,
    input wire logic bit_rate_select_lo,
    tdmssp_tim_if.gen tim
);
    import tdmssp_pkg::*;

    logic [3:0] pin_raw;
    logic [3:0] pin_sync;
    logic mclk_prev_q;
    logic mclk_prev_d;
    logic stb_prev_q;
    logic stb_prev_d;
    logic [4:0] div_q;
    logic [4:0] div_d;
    logic [4:0] div_last;
    logic [4:0] div_half;
    logic mclk_rise;
    logic mclk_fall;
    logic stb_rise;
    logic fast_rate;

    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    assign pin_raw = {tdm_serial_in, slot_strobe, frame_pulse_input, master_clock_in};

    // two-flop synchroniser per pin, only the last stage is read
    for (genvar i = 0; i < 4; i++) begin : g_sync
        logic [SYNC_STAGES-1:0] chain_q;
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                chain_q <= {SYNC_STAGES{SYNC_RESET[i]}};
            end else begin
                chain_q <= {chain_q[SYNC_STAGES-2:0], pin_raw[i]};
            end
        end
        assign pin_sync[i] = chain_q[SYNC_STAGES-1];
    end

    assign mclk_rise = pin_sync[0] && !mclk_prev_q;
    assign mclk_fall = !pin_sync[0] && mclk_prev_q;
    assign stb_rise = pin_sync[2] && !stb_prev_q;
    assign fast_rate = bit_rate_select_lo || bit_rate_select_hi; // R18
    assign div_last = fast_rate ? ASYNC_LAST_256 : ASYNC_LAST_128; // R18
    assign div_half = fast_rate ? ASYNC_HALF_256 : ASYNC_HALF_128;

    // edge history and divider, re-aligned to every strobe
    always_comb begin
        mclk_prev_d = pin_sync[0];
        stb_prev_d = pin_sync[2];
        div_d = div_q;
        if (stb_rise) begin
            div_d = 5'h00; // R19
        end else if (mclk_rise) begin
            div_d = (div_q >= div_last) ? 5'h00 : div_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mclk_prev_q <= 1'b0;
            stb_prev_q <= 1'b0;
            div_q <= 5'h00;
        end else begin
            mclk_prev_q <= mclk_prev_d;
            stb_prev_q <= stb_prev_d;
            div_q <= div_d;
        end
    end

    // direct bit clock at 512 kHz and up, regenerated one below that
    assign tim.mclk_rise = mclk_rise;
    assign tim.mclk_fall = mclk_fall;
    assign tim.fp_low = !pin_sync[1];
    assign tim.stb = pin_sync[2];
    assign tim.stb_rise = stb_rise;
    assign tim.din = pin_sync[3];
    assign tim.bit_rise = async_select ? (mclk_rise && div_q == 5'h00) : mclk_rise; // R19
    assign tim.bit_fall = async_select ? (mclk_rise && div_q == div_half) : mclk_fall; // R19
endmodule

// ---- src/tdmssp_port.sv ----
// serial voice/data port: 32-slot tdm frame mode and strobed single-slot mode
// Function
// R1 - tdm mode: d channel bits gather into and send from one 8-bit register
// R2 - d channel disabled: still receive, but tri-state d slot and interrupt
// R3 - slow rate bit: one d bit per frame, else two bits per frame
// R4 - fast rate read gives four di-bits, oldest frame in the top di-bit
// R5 - fast rate written byte goes out over next four frames, top di-bit first
// R6 - without a new write the d transmit byte is sent again and again
// R7 - d transmit register resets to all ones on either reset
// R8 - interrupt every 4th frame at bit cell 3, slow: every 8th at cell 2
// R9 - interrupt removed by d register access or next frame pulse, earlier wins
// R10 - processor must finish its d register access before next frame pulse
// R11 - c channel enabled: send c register in slot 1, msb first, resets to ones
// R12 - received c channel byte always stored, enable or not
// R13 - c channel disabled: c slot output held tri-stated
// R14 - slots 2 and 3 carry b1 and b2, tx and rx pick independently
// R15 - tdm: b slot without valid transmit path is tri-stated
// R16 - tdm: receive select bit picks b1 or b2 for the receive path
// R17 - strobed mode: one strobe-defined slot, c, d and b select have no effect
// R18 - async and rate bits set the strobed bit rate
// R19 - 512 kHz and up use bit clock directly, slower regenerate from master
// R20 - sync strobed: sample on falling, launch on rising, inside slot only
// R21 - strobed output tri-stated without strobe, quiet code with no tx path
// R22 - no frame delay synchronous, exactly one frame delay asynchronous
// R23 - tdm frame: 32 slots of 8 bits, slot 0 after frame pulse is d
// R24 - tdm: sample at 3/4 of bit cell, launch at start of cell
// R25 - frame starts on low frame pulse at a falling clock edge
// R26 - interrupt active low, held from assertion until a removal event
`timescale 1ns/1ps
module tdmssp_port #(
    parameter tdmssp_pkg::tdmssp_byte_t QUIET_BYTE = tdmssp_pkg::QUIET_CODE
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic soft_reset,
    input wire logic strobed_serial_mode,
    input wire logic d_channel_enable,
    input wire logic c_channel_enable,
    input wire logic d_channel_slow_rate,
    input wire logic receive_b_channel_select,
    input wire logic async_select,
    input wire logic bit_rate_select_hi,
    input wire logic bit_rate_select_lo,
    input wire logic tx_path_valid,
    input wire logic tx_b_channel_select,
    input wire logic rx_path_valid,
    input wire tdmssp_pkg::tdmssp_byte_t tx_voice_byte,
    output tdmssp_pkg::tdmssp_byte_t rx_voice_byte,
    output logic rx_voice_valid,
    input wire tdmssp_pkg::tdmssp_byte_t reg_addr,
    input wire tdmssp_pkg::tdmssp_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tdmssp_pkg::tdmssp_byte_t reg_rdata,
    input wire logic master_clock_in,
    input wire logic frame_pulse_input,
    input wire logic slot_strobe,
    input wire logic tdm_serial_in,
    output logic tdm_serial_out,
    output logic tdm_serial_out_oe,
    output logic d_channel_irq_n,
    output logic d_channel_irq_oe
);
    import tdmssp_pkg::*;

    tdmssp_tim_if tim ();

    tdmssp_clk_gen u_clk_gen (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .master_clock_in(master_clock_in),
        .frame_pulse_input(frame_pulse_input),
        .slot_strobe(slot_strobe),
        .tdm_serial_in(tdm_serial_in),
        .async_select(async_select),
        .bit_rate_select_hi(bit_rate_select_hi),
        .bit_rate_select_lo(bit_rate_select_lo),
        .tim(tim)
    );

    // register group
    tdmssp_byte_t c_tx_q, c_tx_d, d_tx_q, d_tx_d, rdata_q, rdata_d;
    // tdm group
    logic [8:0] hcnt_q, hcnt_d, lcnt;
    logic [2:0] fcnt_q, fcnt_d;
    tdmssp_byte_t d_rx_q, d_rx_d, d_sh_q, d_sh_d, d_cur;
    tdmssp_byte_t c_sh_q, c_sh_d, c_rx_q, c_rx_d, b_sh_q, b_sh_d, b_tx_q, b_tx_d;
    logic irq_n_q, irq_n_d, irq_set;
    logic frame_start, t_launch, t_sample, t_bit, t_oe, t_deliver;
    tdmssp_byte_t t_rxb;
    logic [4:0] l_slot, s_slot;
    logic [2:0] l_pos, s_pos, f_last, irq_pos, d_bits;
    logic d_access;
    // strobed group
    tdmssp_slot_t ss_q, ss_d;
    logic [2:0] scnt_q, scnt_d;
    tdmssp_byte_t s_tx_q, s_tx_d, s_next_q, s_next_d, s_sh_q, s_sh_d, s_hold_q, s_hold_d;
    tdmssp_byte_t s_cur, s_byte, s_rxb;
    logic s_launch, s_bit, s_deliver;
    // output group
    logic dout_q, dout_d, oe_q, oe_d, irq_oe_q, irq_oe_d, rxv_q, rxv_d;
    tdmssp_byte_t rxb_q, rxb_d;

    assign d_access = (reg_wr || reg_rd) && (reg_addr == D_CHAN_ADDR);

    // control port writes, reads and software reset
    always_comb begin
        c_tx_d = c_tx_q;
        d_tx_d = d_tx_q;
        rdata_d = rdata_q;
        if (soft_reset) begin
            c_tx_d = C_TX_RESET; // R11
            d_tx_d = D_TX_RESET; // R7
        end else if (reg_wr) begin
            if (reg_addr == C_CHAN_ADDR) begin
                c_tx_d = reg_wdata;
            end
            if (reg_addr == D_CHAN_ADDR) begin
                d_tx_d = reg_wdata; // R1
            end
        end
        if (reg_rd) begin
            case (reg_addr)
                C_CHAN_ADDR: rdata_d = c_rx_q; // R12
                D_CHAN_ADDR: rdata_d = d_rx_q; // R4
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            c_tx_q <= C_TX_RESET; // R11
            d_tx_q <= D_TX_RESET; // R7
            rdata_q <= 8'h00;
        end else begin
            c_tx_q <= c_tx_d;
            d_tx_q <= d_tx_d;
            rdata_q <= rdata_d;
        end
    end

    // tdm frame timing: half-bit counter on falling clock edges
    assign frame_start = !strobed_serial_mode && tim.mclk_fall && tim.fp_low; // R25
    assign lcnt = frame_start ? 9'h000 : hcnt_q + 9'h001; // R23
    assign t_launch = !strobed_serial_mode && tim.mclk_fall && !lcnt[0]; // R24
    assign t_sample = !strobed_serial_mode && tim.mclk_rise && hcnt_q[0]; // R24
    assign l_slot = lcnt[8:4];
    assign l_pos = lcnt[3:1];
    assign s_slot = hcnt_q[8:4];
    assign s_pos = hcnt_q[3:1];
    assign f_last = d_channel_slow_rate ? D_SLOW_LAST_FRAME : D_FAST_LAST_FRAME; // R8
    assign irq_pos = d_channel_slow_rate ? D_SLOW_IRQ_BIT : D_FAST_IRQ_BIT; // R8
    assign d_bits = d_channel_slow_rate ? D_SLOW_BITS : D_FAST_BITS; // R3
    assign irq_set = t_launch && l_slot == SLOT_D && l_pos == irq_pos && fcnt_q == f_last; // R8

    // tdm slot engine: d, c and b channels
    always_comb begin
        hcnt_d = hcnt_q;
        fcnt_d = fcnt_q;
        d_rx_d = d_rx_q;
        d_sh_d = d_sh_q;
        c_sh_d = c_sh_q;
        c_rx_d = c_rx_q;
        b_sh_d = b_sh_q;
        b_tx_d = b_tx_q;
        irq_n_d = irq_n_q;
        t_bit = 1'b1;
        t_oe = 1'b0;
        t_deliver = 1'b0;
        t_rxb = b_sh_q;
        // first frame of a new byte reloads from the transmit register
        d_cur = (frame_start && fcnt_q >= f_last) ? d_tx_q : d_sh_q; // R5 R6
        if (!strobed_serial_mode && tim.mclk_fall) begin
            hcnt_d = lcnt;
            if (frame_start) begin
                fcnt_d = (fcnt_q >= f_last) ? 3'h0 : fcnt_q + 3'h1;
                b_tx_d = tx_voice_byte;
            end
        end
        if (t_launch) begin
            case (l_slot)
                SLOT_D: begin
                    if (l_pos < d_bits) begin
                        t_bit = d_cur[7]; // R5
                        t_oe = d_channel_enable; // R2
                        d_sh_d = {d_cur[6:0], 1'b1};
                    end
                end
                SLOT_C: begin
                    t_bit = c_tx_q[3'h7 - l_pos]; // R11
                    t_oe = c_channel_enable; // R13
                end
                SLOT_B1, SLOT_B2: begin
                    // low slot bit tells b1 from b2
                    t_bit = b_tx_q[3'h7 - l_pos];
                    t_oe = tx_path_valid && (l_slot[0] == tx_b_channel_select); // R14 R15
                end
                default: t_oe = 1'b0;
            endcase
        end
        if (t_sample) begin
            case (s_slot)
                SLOT_D: begin
                    if (s_pos < d_bits) begin
                        d_rx_d = {d_rx_q[6:0], tim.din}; // R1 R2 R3 R4
                    end
                end
                SLOT_C: begin
                    c_sh_d = {c_sh_q[6:0], tim.din};
                    if (s_pos == 3'h7) begin
                        c_rx_d = {c_sh_q[6:0], tim.din}; // R12
                    end
                end
                SLOT_B1, SLOT_B2: begin
                    if (rx_path_valid && (s_slot[0] == receive_b_channel_select)) begin // R16
                        b_sh_d = {b_sh_q[6:0], tim.din}; // R14
                        if (s_pos == 3'h7) begin
                            t_rxb = {b_sh_q[6:0], tim.din};
                            t_deliver = 1'b1;
                        end
                    end
                end
                default: t_rxb = b_sh_q;
            endcase
        end
        // interrupt: setting wins over removal in the same cycle
        if (irq_set) begin
            irq_n_d = 1'b0; // R8 R26
        end else if (frame_start || d_access) begin
            irq_n_d = 1'b1; // R9 R10
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hcnt_q <= 9'h000;
            fcnt_q <= 3'h0;
            d_rx_q <= RX_RESET;
            d_sh_q <= D_TX_RESET;
            c_sh_q <= RX_RESET;
            c_rx_q <= RX_RESET;
            b_sh_q <= RX_RESET;
            b_tx_q <= QUIET_BYTE;
            irq_n_q <= 1'b1;
        end else begin
            hcnt_q <= hcnt_d;
            fcnt_q <= fcnt_d;
            d_rx_q <= d_rx_d;
            d_sh_q <= d_sh_d;
            c_sh_q <= c_sh_d;
            c_rx_q <= c_rx_d;
            b_sh_q <= b_sh_d;
            b_tx_q <= b_tx_d;
            irq_n_q <= irq_n_d;
        end
    end

    assign s_byte = tx_path_valid ? tx_voice_byte : QUIET_BYTE; // R21

    // strobed slot engine: one 8-bit slot per strobe
    always_comb begin
        ss_d = ss_q;
        scnt_d = scnt_q;
        s_tx_d = s_tx_q;
        s_next_d = s_next_q;
        s_sh_d = s_sh_q;
        s_hold_d = s_hold_q;
        s_launch = 1'b0;
        s_bit = 1'b1;
        s_deliver = 1'b0;
        s_rxb = s_hold_q;
        s_cur = s_tx_q;
        if (!strobed_serial_mode || !tim.stb) begin
            ss_d = SS_IDLE; // R17
        end else begin
            if (tim.stb_rise) begin
                ss_d = SS_SLOT;
                scnt_d = 3'h0;
                // async sends last frame's byte and hands over last frame's capture
                s_cur = async_select ? s_next_q : s_byte; // R22
                s_tx_d = s_cur;
                s_next_d = s_byte;
                s_deliver = async_select; // R22
            end
            if (tim.bit_rise && (ss_q == SS_SLOT || tim.stb_rise)) begin
                s_launch = 1'b1; // R20
                s_bit = s_cur[3'h7 - (tim.stb_rise ? 3'h0 : scnt_q)];
            end
            if (tim.bit_fall && ss_q == SS_SLOT) begin
                s_sh_d = {s_sh_q[6:0], tim.din}; // R20
                scnt_d = scnt_q + 3'h1;
                if (scnt_q == 3'h7) begin
                    ss_d = SS_IDLE;
                    if (async_select) begin
                        s_hold_d = {s_sh_q[6:0], tim.din}; // R22
                    end else begin
                        s_rxb = {s_sh_q[6:0], tim.din}; // R22
                        s_deliver = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ss_q <= SS_IDLE;
            scnt_q <= 3'h0;
            s_tx_q <= QUIET_BYTE;
            s_next_q <= QUIET_BYTE;
            s_sh_q <= RX_RESET;
            s_hold_q <= QUIET_BYTE;
        end else begin
            ss_q <= ss_d;
            scnt_q <= scnt_d;
            s_tx_q <= s_tx_d;
            s_next_q <= s_next_d;
            s_sh_q <= s_sh_d;
            s_hold_q <= s_hold_d;
        end
    end

    // pin and voice outputs, selected by mode
    always_comb begin
        dout_d = dout_q;
        oe_d = oe_q;
        rxb_d = rxb_q;
        rxv_d = 1'b0;
        irq_oe_d = d_channel_enable && !strobed_serial_mode; // R2 R17
        if (strobed_serial_mode) begin
            if (!tim.stb) begin
                oe_d = 1'b0; // R21
            end else if (s_launch) begin
                dout_d = s_bit;
                oe_d = 1'b1;
            end
            if (s_deliver) begin
                rxb_d = s_rxb;
                rxv_d = 1'b1;
            end
        end else begin
            if (t_launch) begin
                dout_d = t_bit;
                oe_d = t_oe; // R15
            end
            if (t_deliver) begin
                rxb_d = t_rxb;
                rxv_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= 1'b1;
            oe_q <= 1'b0;
            irq_oe_q <= 1'b0;
            rxb_q <= RX_RESET;
            rxv_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
            oe_q <= oe_d;
            irq_oe_q <= irq_oe_d;
            rxb_q <= rxb_d;
            rxv_q <= rxv_d;
        end
    end

    assign tdm_serial_out = dout_q;
    assign tdm_serial_out_oe = oe_q;
    assign d_channel_irq_n = irq_n_q;
    assign d_channel_irq_oe = irq_oe_q;
    assign rx_voice_byte = rxb_q;
    assign rx_voice_valid = rxv_q;
    assign reg_rdata = rdata_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    irq_assert_point_a: assert property ($fell(d_channel_irq_n) |-> $past(fcnt_q) == $past(f_last) && $past(l_pos) == $past(irq_pos)) // R8
        else $error("interrupt asserted outside its bit cell");
    irq_removal_a: assert property (frame_start && !d_channel_irq_n |=> d_channel_irq_n) // R9
        else $error("interrupt not removed at frame pulse");
    irq_hold_a: assert property (!d_channel_irq_n && !frame_start && !d_access |=> !d_channel_irq_n) // R26
        else $error("interrupt dropped without a removal event");
    tx_reset_ones_a: assert property (soft_reset |=> d_tx_q == D_TX_RESET && c_tx_q == C_TX_RESET) // R7 R11
        else $error("transmit registers not preset to ones");
    d_tx_keep_a: assert property (!soft_reset && !reg_wr |=> $stable(d_tx_q)) // R6
        else $error("d transmit register changed without a write");
    irq_tri_a: assert property (!d_channel_enable |=> !d_channel_irq_oe) // R2
        else $error("interrupt driven while d channel disabled");
    c_slot_tri_a: assert property (t_launch && l_slot == SLOT_C && !c_channel_enable |=> !tdm_serial_out_oe) // R13
        else $error("c slot driven while c channel disabled");
    strobe_tri_a: assert property (strobed_serial_mode && !tim.stb |=> !tdm_serial_out_oe) // R21
        else $error("strobed output driven without strobe");
    c_rx_store_a: assert property (t_sample && s_slot == SLOT_C && s_pos == 3'h7 |=> c_rx_q[0] == $past(tim.din)) // R12
        else $error("received c byte not stored");
    slow_rate_a: assert property (t_sample && s_slot == SLOT_D && s_pos == 3'h1 && d_channel_slow_rate |=> $stable(d_rx_q)) // R3
        else $error("second d bit shifted at slow rate");
endmodule

// ---- verification/tdmssp_link_model.sv ----
// link partner: tdm frame clock, frame pulse and data in, output slot capture
`timescale 1ns/1ps
module tdmssp_link_model (
    output logic master_clock_in,
    output logic frame_pulse_input,
    output logic tdm_serial_in,
    input wire logic tdm_serial_out,
    input wire logic tdm_serial_out_oe,
    output int frames,
    output logic [7:0] cap_d,
    output logic [7:0] cap_c,
    output logic [7:0] cap_b,
    output logic c_oe_seen
);
    // bytes sent in slots 0..3: d bits "10", c byte, b1, b2
    logic [7:0] slot_bytes [4] = '{8'h80, 8'h3C, 8'h5A, 8'hC3};
    // one bit cell is two clock periods; frame pulse spans the cell's first fall
    initial begin
        master_clock_in = 1'b1;
        frame_pulse_input = 1'b1;
        tdm_serial_in = 1'b0;
        frames = 0;
        cap_d = 8'h00;
        cap_c = 8'h00;
        cap_b = 8'h00;
        c_oe_seen = 1'b0;
        forever begin
            for (int s = 0; s < 32; s++) begin
                for (int b = 0; b < 8; b++) begin
                    #100;
                    if (s == 0 && b == 0) begin
                        frame_pulse_input = 1'b0;
                        frames++;
                    end
                    #100 master_clock_in = 1'b0;
                    // unused slots toggle so stale data never looks valid
                    tdm_serial_in = (s < 4) ? slot_bytes[s][7-b] : ~tdm_serial_in;
                    #100 frame_pulse_input = 1'b1;
                    #100 master_clock_in = 1'b1;
                    #200 master_clock_in = 1'b0;
                    #200 master_clock_in = 1'b1;
                    // sample at the three-quarter point of the cell
                    if (s == 0 && b < 2 && tdm_serial_out_oe)
                        cap_d = {cap_d[6:0], tdm_serial_out};
                    if (s == 1)
                        c_oe_seen = c_oe_seen | tdm_serial_out_oe;
                    if (s == 1 && tdm_serial_out_oe)
                        cap_c = {cap_c[6:0], tdm_serial_out};
                    if (s == 2 && tdm_serial_out_oe)
                        cap_b = {cap_b[6:0], tdm_serial_out};
                end
            end
        end
    end
endmodule

// ---- verification/tdm_strobed_serial_port_test.sv ----
// self-checking bench for the serial voice/data port in tdm frame mode
`timescale 1ns/1ps
module tdm_strobed_serial_port_test;
    import tdmssp_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic soft_reset = 1'b0, strobed_serial_mode = 1'b0, d_channel_enable = 1'b1;
    logic c_channel_enable = 1'b0, d_channel_slow_rate = 1'b0, receive_b_channel_select = 1'b1;
    logic async_select = 1'b0, bit_rate_select_hi = 1'b0, bit_rate_select_lo = 1'b0;
    logic tx_path_valid = 1'b1, tx_b_channel_select = 1'b0, rx_path_valid = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, slot_strobe = 1'b0;
    tdmssp_byte_t tx_voice_byte = 8'h96, reg_addr = 8'h00, reg_wdata = 8'h00;
    tdmssp_byte_t rx_voice_byte, reg_rdata, cap_d, cap_c, cap_b;
    logic rx_voice_valid, master_clock_in, frame_pulse_input, tdm_serial_in, c_oe_seen;
    logic tdm_serial_out, tdm_serial_out_oe, d_channel_irq_n, d_channel_irq_oe;
    int frames, n0, mismatches = 0, checks_done = 0;

    tdmssp_port uut (.sys_clk, .nrst, .soft_reset, .strobed_serial_mode, .d_channel_enable,
        .c_channel_enable, .d_channel_slow_rate, .receive_b_channel_select, .async_select,
        .bit_rate_select_hi, .bit_rate_select_lo, .tx_path_valid, .tx_b_channel_select,
        .rx_path_valid, .tx_voice_byte, .rx_voice_byte, .rx_voice_valid, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .master_clock_in, .frame_pulse_input,
        .slot_strobe, .tdm_serial_in, .tdm_serial_out, .tdm_serial_out_oe,
        .d_channel_irq_n, .d_channel_irq_oe);
    tdmssp_link_model link (.master_clock_in, .frame_pulse_input, .tdm_serial_in,
        .tdm_serial_out, .tdm_serial_out_oe, .frames, .cap_d, .cap_c, .cap_b, .c_oe_seen);

    initial forever #25 sys_clk = ~sys_clk;

    task automatic check8(input tdmssp_byte_t got, input tdmssp_byte_t exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle register strobe; read data is settled at the following fall
    task automatic reg_access(input logic wr, input tdmssp_byte_t addr, input tdmssp_byte_t data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
    task automatic wait_frames(input int n);
        int t;
        t = frames + n;
        for (int i = 0; i < 5000 * n && frames < t; i++) @(negedge sys_clk);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 40000 && d_channel_irq_n !== 1'b0; i++) @(negedge sys_clk);
    endtask
    task automatic complete_run();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // watchdog: the sequence needs about twenty frames
    initial begin
        #4_500_000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (10) @(negedge sys_clk);
        nrst = 1'b1;
        reg_access(1'b0, 8'h20, 8'h00);
        check8(reg_rdata, 8'h00);
        wait_frames(3);
        check8(tdmssp_byte_t'(c_oe_seen), 8'h00);
        reg_access(1'b0, C_CHAN_ADDR, 8'h00);
        check8(reg_rdata, 8'h3C);
        check8(cap_b, tx_voice_byte);
        for (int i = 0; i < 5000 && rx_voice_valid !== 1'b1; i++) @(negedge sys_clk);
        check8(rx_voice_byte, 8'hC3);
        c_channel_enable = 1'b1;
        reg_access(1'b1, C_CHAN_ADDR, 8'hA5);
        wait_frames(2);
        check8(cap_c, 8'hA5);
        wait_irq();
        n0 = frames;
        check8(tdmssp_byte_t'(d_channel_irq_oe), 8'h01);
        reg_access(1'b0, D_CHAN_ADDR, 8'h00);
        check8(reg_rdata, 8'hAA);
        check8(tdmssp_byte_t'(d_channel_irq_n), 8'h01);
        reg_access(1'b1, D_CHAN_ADDR, 8'h1B);
        wait_irq();
        check8(8'(frames - n0), 8'h04);
        check8(cap_d, 8'h1B);
        wait_frames(1);
        repeat (20) @(negedge sys_clk);
        check8(tdmssp_byte_t'(d_channel_irq_n), 8'h01);
        wait_irq();
        check8(cap_d, 8'h1B);
        soft_reset = 1'b1;
        @(negedge sys_clk);
        soft_reset = 1'b0;
        wait_frames(1);
        // frame pulse clears the interrupt still pending from before
        repeat (20) @(negedge sys_clk);
        wait_irq();
        check8(cap_d, D_TX_RESET);
        check8(cap_c, C_TX_RESET);
        // one slow-rate frame shifts a single one behind the "10" di-bits
        d_channel_slow_rate = 1'b1;
        wait_frames(1);
        repeat (40) @(negedge sys_clk);
        reg_access(1'b0, D_CHAN_ADDR, 8'h00);
        check8(reg_rdata, 8'h55);
        reg_access(1'b0, 8'h20, 8'h00);
        check8(reg_rdata, 8'h00);
        d_channel_enable = 1'b0;
        repeat (2) @(negedge sys_clk);
        check8(tdmssp_byte_t'(d_channel_irq_oe), 8'h00);
        strobed_serial_mode = 1'b1;
        repeat (2) @(negedge sys_clk);
        check8(tdmssp_byte_t'(tdm_serial_out_oe), 8'h00);
        complete_run();
    end
endmodule
